// file: common/mode_loader_cfg.svh
// Constants for the reset-time mode vector loader
`ifndef MODE_LOADER_CFG_SVH
`define MODE_LOADER_CFG_SVH
`define MODE_VECTOR_ADDR 32'h000ffff8
`define RESET_VECTOR_ADDR 32'h000ffffc
`define MODE_RESERVED_PATTERN 8'h07
`define MODE_RESERVED_MSB 31
`define MODE_RESERVED_LSB 24
`define BOOT_SEL_INTERNAL 3'h0
`define BOOT_SEL_EXTERNAL 3'h1
`define MODE_REG_RESET 32'h00000000
`define MEM_WAIT_LIMIT_NS 800
`define CLK_PERIOD_NS 8
`define MEM_WAIT_CYCLES (`MEM_WAIT_LIMIT_NS / `CLK_PERIOD_NS)
`endif

// file: common/mode_loader_pkg.sv
// Types for the reset-time mode vector loader
package mode_loader_pkg;
   typedef enum logic [2:0] {
      st_sample = 3'b000,
      st_mode_req = 3'b001,
      st_mode_wait = 3'b010,
      st_vec_req = 3'b011,
      st_vec_wait = 3'b100,
      st_run = 3'b101,
      st_halt = 3'b110
   } loader_state_t;

   typedef struct packed {
      logic req;
      logic [31:0] addr;
   } boot_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] data;
   } boot_rsp_t;

   typedef struct packed {
      logic [2:0] boot_select;
      logic supported;
      logic internal;
   } boot_cfg_t;
endpackage : mode_loader_pkg

// file: src/boot_select_decoder.sv
// Boot-select pin decoder, registered
`timescale 1ns/1ps
`default_nettype none
`include "mode_loader_cfg.svh"
module boot_select_decoder
   import mode_loader_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic capture,
   input wire logic [2:0] pins,
   output boot_cfg_t cfg
);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg <= '0;
      end else if (capture) begin
         cfg.boot_select <= pins;
         cfg.internal <= (pins == `BOOT_SEL_INTERNAL);
         // Only the internal encoding is usable here; external and the rest are not
         cfg.supported <= (pins == `BOOT_SEL_INTERNAL);
      end
   end
endmodule : boot_select_decoder
`default_nettype wire

// file: src/reset_mode_vector_loader.sv
// Reset-time mode vector loader with operating mode register
`timescale 1ns/1ps
`default_nettype none
`include "mode_loader_cfg.svh"
// How it works
// - Pins all low: fetch mode and reset vectors from internal memory.
// - During reset processing fetch mode word, write operating mode register.
// - Once loaded, the device runs in the mode the register holds.
// - Every reset source reloads the operating mode register.
// - Software writes to the operating mode register are ignored.
// - Big endian: byte at vector address is word bits 31 to 24.
module reset_mode_vector_loader
   import mode_loader_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] boot_select_pins,
   output boot_req_t mem_req,
   input wire boot_rsp_t mem_rsp,
   input wire logic sw_mode_wr,
   input wire logic [31:0] sw_mode_wdata,
   output logic [31:0] operating_mode_register,
   output logic [31:0] reset_vector,
   output logic cpu_start,
   output logic mode_pattern_bad,
   output logic boot_fault
);
   // Bounded wait so a missing memory cannot hold the core in reset forever
   localparam logic [7:0] wait_limit = 8'(`MEM_WAIT_CYCLES);

   loader_state_t state;
   boot_cfg_t cfg;
   logic [7:0] wait_cnt;
   logic capture;
   logic mode_taken;
   logic vec_taken;
   logic mode_loaded;
   logic [7:0] reserved_byte;

   assign capture = (state == st_sample);
   // An answer only counts in the wait state of its own fetch
   assign mode_taken = (state == st_mode_wait) && mem_rsp.ack;
   assign vec_taken = (state == st_vec_wait) && mem_rsp.ack;
   // Vector byte sits in the top byte of the big-endian word
   assign reserved_byte = mem_rsp.data[`MODE_RESERVED_MSB:`MODE_RESERVED_LSB];

   boot_select_decoder u_decoder (
      .core_clk(core_clk),
      .rst(rst),
      .capture(capture),
      .pins(boot_select_pins),
      .cfg(cfg)
   );

   function automatic logic timed_out(input logic [7:0] cnt);
      timed_out = (cnt == wait_limit);
   endfunction : timed_out

   function automatic logic is_wait_state(input loader_state_t s);
      is_wait_state = (s == st_mode_wait) || (s == st_vec_wait);
   endfunction : is_wait_state

   // Both fetches read fixed vector addresses in the internal space
   function automatic logic [31:0] vector_addr(input logic mode_fetch);
      vector_addr = mode_fetch ? `MODE_VECTOR_ADDR : `RESET_VECTOR_ADDR;
   endfunction : vector_addr

   // rst stands for every reset source, so each one restarts the load
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= st_sample;
      end else begin
         case (state)
            st_sample: begin
               state <= st_mode_req;
            end
            st_mode_req: begin
               // Decoder output is valid one cycle after capture
               if (cfg.internal) begin
                  state <= st_mode_wait;
               end else begin
                  // No fetch from a space this block cannot reach
                  state <= st_halt;
               end
            end
            st_mode_wait: begin
               if (mem_rsp.ack) begin
                  state <= st_vec_req;
               end else if (timed_out(wait_cnt)) begin
                  state <= st_halt;
               end
            end
            st_vec_req: begin
               if (mode_loaded) begin
                  state <= st_vec_wait;
               end else begin
                  state <= st_halt;
               end
            end
            st_vec_wait: begin
               if (mem_rsp.ack) begin
                  state <= st_run;
               end else if (timed_out(wait_cnt)) begin
                  state <= st_halt;
               end
            end
            st_run: begin
               // Left only through the next reset, of whatever source
               state <= st_run;
            end
            st_halt: begin
               // Parked until reset; the fault output stays up meanwhile
               state <= st_halt;
            end
            default: begin
               state <= st_halt;
            end
         endcase
      end
   end

   // Each fetch gets its own wait budget; the count parks at the limit
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wait_cnt <= 8'h00;
      end else if (state == st_mode_req || state == st_vec_req) begin
         wait_cnt <= 8'h00;
      end else if (is_wait_state(state) && !timed_out(wait_cnt)) begin
         wait_cnt <= wait_cnt + 8'h01;
      end
   end

   // Memory request held high for the whole wait; internal space only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mem_req <= '0;
      end else if (state == st_mode_req && cfg.internal) begin
         mem_req.req <= 1'b1;
         mem_req.addr <= vector_addr(1'b1);
      end else if (state == st_vec_req && mode_loaded) begin
         mem_req.req <= 1'b1;
         mem_req.addr <= vector_addr(1'b0);
      end else if (mem_rsp.ack) begin
         mem_req.req <= 1'b0;
      end else if (state == st_halt) begin
         // A fetch abandoned on timeout must not stay open on the bus
         mem_req.req <= 1'b0;
      end
   end

   // Only the mode fetch writes it; sw_mode_wr is dropped on purpose
   always_ff @(posedge core_clk) begin
      if (rst) begin
         operating_mode_register <= `MODE_REG_RESET;
      end else if (mode_taken) begin
         // Word as fetched; vector byte lands in bits 31:24
         operating_mode_register <= mem_rsp.data;
      end
   end

   // Flags a reserved byte that differs from the fixed pattern; no correction
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode_pattern_bad <= 1'b0;
      end else if (mode_taken) begin
         mode_pattern_bad <= (reserved_byte != `MODE_RESERVED_PATTERN);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reset_vector <= 32'h00000000;
      end else if (vec_taken) begin
         reset_vector <= mem_rsp.data;
      end
   end

   // Set only by the mode fetch of this reset, so a start cannot outrun the load
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode_loaded <= 1'b0;
      end else if (mode_taken) begin
         mode_loaded <= 1'b1;
      end
   end

   // Core may only start after the mode register is in place
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cpu_start <= 1'b0;
      end else if (state == st_run) begin
         cpu_start <= 1'b1;
      end else if (vec_taken && mode_loaded) begin
         cpu_start <= 1'b1;
      end else begin
         cpu_start <= 1'b0;
      end
   end

   // Unsupported pins or a dead memory stop the boot rather than guess
   always_ff @(posedge core_clk) begin
      if (rst) begin
         boot_fault <= 1'b0;
      end else if (state == st_mode_req && !cfg.supported) begin
         boot_fault <= 1'b1;
      end else if (state == st_halt) begin
         boot_fault <= 1'b1;
      end else if (is_wait_state(state) && !mem_rsp.ack && timed_out(wait_cnt)) begin
         // Memory never answered; stopping beats running from an unknown vector
         boot_fault <= 1'b1;
      end else begin
         boot_fault <= 1'b0;
      end
   end

   // Software write port reaches nothing: the register is load-only
   logic unused_sw;
   assign unused_sw = sw_mode_wr ^ (^sw_mode_wdata) ^ (^cfg.boot_select);
endmodule : reset_mode_vector_loader
`default_nettype wire

// file: test/boot_memory_model.sv
// Boot memory answering vector fetches after a set lag
`timescale 1ns/1ps
`default_nettype none
`include "mode_loader_cfg.svh"
module boot_memory_model import mode_loader_pkg::*; (
   input wire logic core_clk,
   input wire boot_req_t mem_req,
   input wire logic [7:0] lag,
   input wire logic [31:0] mode_word,
   output boot_rsp_t mem_rsp = '0
);
   logic [7:0] cnt = 8'h00;
   always_ff @(posedge core_clk) begin
      cnt <= mem_req.req ? cnt + 8'h01 : 8'h00;
      mem_rsp.ack <= mem_req.req && cnt == lag;
      if (mem_req.req && cnt == lag) begin
         // Mode word stored with its vector byte on top
         mem_rsp.data <= mem_req.addr == `MODE_VECTOR_ADDR ? mode_word : ~mode_word;
      end else begin
         // Idle bus toggles so a stale word never passes for an answer
         mem_rsp.data <= ~mem_rsp.data;
      end
   end
endmodule : boot_memory_model
`default_nettype wire

// file: test/reset_mode_vector_loader_properties.sv
// Checker for the mode vector loader
`timescale 1ns/1ps
`default_nettype none
`include "mode_loader_cfg.svh"
module mode_loader_checker import mode_loader_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] boot_select_pins,
   input wire boot_req_t mem_req,
   input wire boot_rsp_t mem_rsp,
   input wire logic sw_mode_wr,
   input wire logic [31:0] operating_mode_register,
   input wire logic cpu_start,
   input wire logic mode_pattern_bad
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence mode_ack_s;
      mem_req.req && mem_req.addr == `MODE_VECTOR_ADDR && mem_rsp.ack;
   endsequence
   chk_mode_fetch: assert property ($fell(rst) && boot_select_pins == 3'h0 |->
      ##[1:3] mem_req.req && mem_req.addr == `MODE_VECTOR_ADDR) else $error("fetch");
   chk_mode_load: assert property (mode_ack_s |=>
      operating_mode_register == $past(mem_rsp.data)) else $error("load");
   chk_byte_order: assert property (mode_ack_s |=>
      mode_pattern_bad == ($past(mem_rsp.data[31:24]) != 8'h07)) else $error("byte");
   chk_vec_order: assert property (mode_ack_s |=> !mem_req.req ##[1:3]
      mem_req.req && mem_req.addr == `RESET_VECTOR_ADDR) else $error("order");
   chk_mode_hold: assert property (cpu_start |=>
      cpu_start && $stable(operating_mode_register)) else $error("hold");
   chk_sw_ignored: assert property (sw_mode_wr && !mem_rsp.ack |=>
      $stable(operating_mode_register)) else $error("write");
   chk_reset_clear: assert property (disable iff (1'b0) rst |=> !cpu_start &&
      operating_mode_register == `MODE_REG_RESET) else $error("reset");
endmodule : mode_loader_checker
bind reset_mode_vector_loader mode_loader_checker chk_i (.core_clk(core_clk), .rst(rst),
   .boot_select_pins(boot_select_pins), .mem_req(mem_req), .mem_rsp(mem_rsp),
   .sw_mode_wr(sw_mode_wr), .operating_mode_register(operating_mode_register),
   .cpu_start(cpu_start), .mode_pattern_bad(mode_pattern_bad));
`default_nettype wire

// file: test/reset_mode_vector_loader_bench.sv
// Self-checking bench for the mode vector loader
`timescale 1ns/1ps
`default_nettype none
`include "mode_loader_cfg.svh"
module reset_mode_vector_loader_bench import mode_loader_pkg::*; ();
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic sw_wr = 1'b0;
   logic [2:0] pins = 3'h0;
   logic [7:0] lag = 8'h00;
   logic [31:0] mword = 32'h0, wdata = 32'h0, omr, rv;
   logic start, bad, fault;
   boot_req_t mem_req;
   boot_rsp_t mem_rsp;
   integer n_errors = 0, n_compared = 0, seed = 32'h898d, i;
   logic [31:0] exp_mode_q[$];
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      sw_wr <= 1'($random(seed));
      wdata <= $random(seed);
   end
   reset_mode_vector_loader dut (.core_clk(core_clk), .rst(rst), .boot_select_pins(pins),
      .mem_req(mem_req), .mem_rsp(mem_rsp), .sw_mode_wr(sw_wr), .sw_mode_wdata(wdata),
      .operating_mode_register(omr), .reset_vector(rv), .cpu_start(start),
      .mode_pattern_bad(bad), .boot_fault(fault));
   boot_memory_model mem (.core_clk(core_clk), .mem_req(mem_req), .lag(lag),
      .mode_word(mword), .mem_rsp(mem_rsp));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   // Every boot starts from a full reset, so each accepted boot also tests the reload
   task automatic boot(input logic [2:0] p, input logic [7:0] l, input logic [31:0] mw);
      logic ok;
      // Reference: only the internal code boots, and only inside the wait budget
      ok = p == `BOOT_SEL_INTERNAL && l < `MEM_WAIT_CYCLES;
      if (ok)
         exp_mode_q.push_back(mw);
      @(posedge core_clk);
      rst <= 1'b1;
      pins <= p;
      lag <= l;
      mword <= mw;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      for (i = 0; i < 400 && start !== 1'b1 && fault !== 1'b1; i++)
         @(posedge core_clk);
      if (i == 400) begin
         n_errors++;
         close_out();
      end
      repeat (6) @(posedge core_clk);
      chk("start", 32'(ok), 32'(start));
      chk("fault", 32'(!ok), 32'(fault));
      if (ok) begin
         chk("mode", exp_mode_q.pop_front(), omr);
         chk("vector", ~mw, rv);
         chk("pattern", 32'(mw[31:24] != `MODE_RESERVED_PATTERN), 32'(bad));
      end
      $display("test pins %h lag %0d done", p, l);
   endtask : boot
   initial begin
      boot(3'h0, 8'h00, {8'h07, 24'($random(seed))});
      boot(3'h0, 8'h14, {8'h07, 24'($random(seed))});
      boot(3'h0, 8'h02, 32'h06a5c3e1);
      // Refused code on purpose; the external vector code is never offered
      boot(3'h4, 8'h00, 32'h07000000);
      boot(3'h0, 8'h96, 32'h07000000);
      close_out();
   end
endmodule : reset_mode_vector_loader_bench
`default_nettype wire
